// ---- hdl/rsdp_top.sv ----
// Command/address front end of a registered memory module, with
// presence-detect slave and AHB-Lite status/mode registers.
// Assumes host inputs synchronous to hclk; hclk is the redriven module clock.
//
// What this block does
// - latch mode high: forward one clock later
// - latch mode low: forward without added clock
// - read latency 2 or 3, plus one registered
// - bank selects and row address open rows
// - read/write address gives burst start column
// - burst lengths 1,2,4,8,full; terminate honoured
// - auto precharge closes row after burst
// - new column accepted every clock
// - banks precharge independently during other access
// - auto refresh, self refresh, power-down modes
// - all inputs sampled on rising clock
// - presence store holds 256 bytes
// - presence store is strap-addressed I2C slave
`timescale 1ns/1ns
`include "rsdp_regs.svh"

module rsdp_top
  import rsdp_pkg::*;
(
  input  wire logic                   hclk,
  input  wire logic                   hresetn,
  input  wire logic                   hsel,
  input  wire logic [31:0]            haddr,
  input  wire logic [1:0]             htrans,
  input  wire logic                   hwrite,
  input  wire logic [2:0]             hsize,
  input  wire logic                   hready,
  input  wire logic [31:0]            hwdata,
  output logic [31:0]                 hrdata,
  output logic                        hreadyout,
  output logic                        hresp,
  input  wire logic                   input_latch_mode_pin,
  input  wire rsdp_cmd_type           host_cmd,
  output rsdp_cmd_type                mem_cmd,
  output logic [`RSDP_COL_W-1:0]      burst_col,
  output logic                        burst_valid,
  input  wire logic [`RSDP_DQ_W-1:0]  wdata_in,
  input  wire logic                   wdata_valid,
  output logic                        wdata_ready,
  output logic [`RSDP_DQ_W-1:0]       mem_wdata,
  output logic                        mem_wvalid,
  input  wire logic                   mem_wready,
  input  wire logic                   scl_in,
  input  wire logic                   sda_in,
  output logic                        sda_out,
  output logic                        sda_oe_n,
  input  wire logic [2:0]             presence_slave_addr_strap
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  rsdp_cmd_type            cap;
  rsdp_cmd_type            eff;
  rsdp_op_type             op;
  logic [3:0]              mode;
  logic [2:0]              rd_latency;
  logic [3:0]              bank_open;
  rsdp_pwr_type            pstate;
  logic [`RSDP_COL_W-1:0]  burst_left;
  logic [`RSDP_COL_W-1:0]  len_mask;
  logic [`RSDP_COL_W-1:0]  next_col;
  logic [1:0]              burst_bank;
  logic                    burst_ap;
  logic                    burst_end;
  logic                    is_full;
  logic                    is_rw;

  // ----------------------------------------
  // Command path
  // ----------------------------------------
  // rising-edge input sampling
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      cap <= RSDP_CMD_IDLE;
    else
      cap <= host_cmd;
  end

  assign eff   = input_latch_mode_pin ? cap : host_cmd;
  assign op    = rsdp_decode(eff);
  assign is_rw = (op == OP_READ) || (op == OP_WRITE);

  // Output stage drives the memory parts
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mem_cmd <= RSDP_CMD_IDLE;
    else
      mem_cmd <= eff;
  end

  a_buffered_pass: assert property (!input_latch_mode_pin |=> mem_cmd == $past(host_cmd))
    else $error("buffered command not forwarded");
  a_registered_delay: assert property (input_latch_mode_pin ##1 input_latch_mode_pin
    |=> mem_cmd == $past(host_cmd, 2))
    else $error("registered command not delayed one clock");

  // ----------------------------------------
  // Burst column generation
  // ----------------------------------------
  // Burst length code to column mask; full page wraps the whole row
  function automatic logic [`RSDP_COL_W-1:0] burst_mask(input logic [2:0] code);
    logic [`RSDP_COL_W-1:0] m;
    case (code)
      3'h0:    m = 9'h000;
      3'h1:    m = 9'h001;
      3'h2:    m = 9'h003;
      3'h3:    m = 9'h007;
      default: m = 9'h1FF;
    endcase
    return m;
  endfunction

  assign len_mask  = burst_mask(mode[2:0]);
  assign is_full   = (mode[2:0] == `RSDP_LEN_FULL);
  assign next_col  = (burst_col & ~len_mask) | ((burst_col + 9'h001) & len_mask);
  assign burst_end = burst_valid && !is_full && (burst_left == '0);

  // start column from the command address
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      burst_col   <= '0;
      burst_left  <= '0;
      burst_valid <= 1'b0;
      burst_bank  <= 2'h0;
      burst_ap    <= 1'b0;
    end
    else if (is_rw)
    begin
      burst_col   <= eff.row_column_address[`RSDP_COL_W-1:0];
      burst_left  <= len_mask;
      burst_valid <= 1'b1;
      burst_bank  <= eff.bank;
      burst_ap    <= eff.row_column_address[`RSDP_AP_BIT];
    end
    else if ((op == OP_BTERM) || burst_end)
      burst_valid <= 1'b0;
    else if (burst_valid)
    begin
      burst_col  <= next_col;
      burst_left <= burst_left - 9'h001;
    end
  end

  a_burst_start: assert property (is_rw |=> burst_col == $past(eff.row_column_address[8:0]))
    else $error("burst start column wrong");

  sequence s_rw_len4;
    is_rw && (mode[2:0] == 3'h2);
  endsequence
  sequence s_quiet4;
    (!is_rw && (op != OP_BTERM))[*4];
  endsequence
  // four-location burst ends after four columns
  a_burst_len4: assert property (s_rw_len4 ##1 s_quiet4 |=> !burst_valid)
    else $error("burst of four did not end on time");

  // ----------------------------------------
  // Bank state and power modes
  // ----------------------------------------
  // each bank closes and opens on its own
  // bank select picks the bank to open
  for (genvar g = 0; g < 4; g++)
  begin : g_bank
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        bank_open[g] <= 1'b0;
      else if ((op == OP_ACT) && (eff.bank == 2'(g)))
        bank_open[g] <= 1'b1;
      else if (((op == OP_PRE) && (eff.row_column_address[`RSDP_AP_BIT] || (eff.bank == 2'(g))))
               || (burst_end && burst_ap && (burst_bank == 2'(g))))
        bank_open[g] <= 1'b0;
    end
  end

  a_bank_opens: assert property ((op == OP_ACT) |=> bank_open[$past(eff.bank)])
    else $error("activated bank not open");
  a_auto_close: assert property (burst_end && burst_ap && !(op == OP_ACT) && !is_rw
    |=> !bank_open[$past(burst_bank)])
    else $error("auto precharge did not close bank");

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      pstate <= PS_IDLE;
    else
    begin
      case (pstate)
        PS_IDLE:
        begin
          if (op == OP_REF)
            pstate <= eff.cke ? PS_AREF : PS_SELF;
          else if (!eff.cke)
            pstate <= PS_DOWN;
        end
        PS_AREF:
          pstate <= PS_IDLE;
        default:
        begin
          if (eff.cke)
            pstate <= PS_IDLE;
        end
      endcase
    end
  end

  // refresh with clock enable low enters self refresh
  a_self_refresh: assert property ((pstate == PS_IDLE) && (op == OP_REF) && !eff.cke
    |=> pstate == PS_SELF)
    else $error("self refresh not entered");

  // ----------------------------------------
  // Write data buffering
  // ----------------------------------------
  logic [`RSDP_DQ_W-1:0] f_data;
  logic                  f_valid;
  logic                  f_pop;

  rsdp_fifo #(.WIDTH(`RSDP_DQ_W), .DEPTH(`RSDP_FIFO_DEPTH)) u_fifo
  (
    .clk       (hclk),
    .rst_n     (hresetn),
    .in_data   (wdata_in),
    .in_valid  (wdata_valid),
    .in_ready  (wdata_ready),
    .out_data  (f_data),
    .out_valid (f_valid),
    .out_ready (f_pop)
  );

  // Output word moves on only when the memory side takes it
  assign f_pop = f_valid && (!mem_wvalid || mem_wready);

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      mem_wdata  <= '0;
      mem_wvalid <= 1'b0;
    end
    else if (f_pop)
    begin
      mem_wdata  <= f_data;
      mem_wvalid <= 1'b1;
    end
    else if (mem_wready)
      mem_wvalid <= 1'b0;
  end

  // ----------------------------------------
  // AHB-Lite register slave
  // ----------------------------------------
  logic        take;
  logic        dp_write;
  logic [7:0]  dp_addr;
  logic [31:0] rd_word;
  logic [31:0] status;

  assign take = hsel && htrans[1] && hready && (hsize == 3'b010);

  // Status word from live block state
  always_comb
  begin
    status = 32'h0000_0000;
    status[`RSDP_ST_BANK +: 4]  = bank_open;
    status[`RSDP_ST_PWR +: 2]   = pstate;
    status[`RSDP_ST_BURST]      = burst_valid;
    status[`RSDP_ST_LATCH]      = input_latch_mode_pin;
    status[`RSDP_ST_LAT +: 3]   = rd_latency;
  end

  // Address decode; unmapped reads return zero
  always_comb
  begin
    if (haddr[7:0] == `RSDP_MODE_OFS)
      rd_word = {28'h0000000, mode};
    else if (haddr[7:0] == `RSDP_STATUS_OFS)
      rd_word = status;
    else
      rd_word = 32'h0000_0000;
  end

  // Zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      hrdata    <= 32'h0000_0000;
      dp_write  <= 1'b0;
      dp_addr   <= 8'h00;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      dp_write  <= take && hwrite;
      dp_addr   <= haddr[7:0];
      if (take && !hwrite)
        hrdata <= rd_word;
    end
  end

  // Mode register: burst length and latency grade
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      mode <= `RSDP_MODE_RST;
    else if (dp_write && (dp_addr == `RSDP_MODE_OFS))
      mode <= hwdata[3:0];
  end

  // latency: grade plus one when latched
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      rd_latency <= `RSDP_CL_SLOW;
    else
      rd_latency <= (mode[`RSDP_MODE_CL3] ? `RSDP_CL_SLOW : `RSDP_CL_FAST)
                    + {2'b00, input_latch_mode_pin};
  end

  // reported latency tracks grade and mode pin
  a_read_latency: assert property (##1 rd_latency ==
    ($past(mode[3]) ? 3'h3 : 3'h2) + {2'b00, $past(input_latch_mode_pin)})
    else $error("read latency wrong");
  // software burst length reaches the mode
  a_mode_write: assert property (dp_write && (dp_addr == 8'h00) |=> mode == $past(hwdata[3:0]))
    else $error("mode write lost");

  // ----------------------------------------
  // Presence-detect I2C slave
  // ----------------------------------------
  rsdp_i2c_type i_state;
  logic         scl_q;
  logic         sda_q;
  logic [3:0]   bit_cnt;
  logic [7:0]   shreg;
  logic [7:0]   ptr;
  logic [7:0]   pd_rdata;
  logic         nack;
  logic         scl_rise;
  logic         scl_fall;
  logic         start_c;
  logic         stop_c;
  logic         addr_match;
  logic         receiving;
  logic         pd_we;

  assign scl_rise   = scl_in && !scl_q;
  assign scl_fall   = !scl_in && scl_q;
  assign start_c    = scl_in && scl_q && sda_q && !sda_in;
  assign stop_c     = scl_in && scl_q && !sda_q && sda_in;
  assign addr_match = (shreg[7:1] == {`RSDP_PD_TYPE, presence_slave_addr_strap});
  assign receiving  = (i_state == I_ADDR) || (i_state == I_WORD) || (i_state == I_WRITE);
  assign pd_we      = scl_fall && (i_state == I_WRITE) && (bit_cnt == 4'h7);

  rsdp_store u_store
  (
    .clk   (hclk),
    .we    (pd_we),
    .addr  (ptr),
    .wdata (shreg),
    .rdata (pd_rdata)
  );

  // Previous line levels for edge and condition detection
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      scl_q   <= 1'b1;
      sda_q   <= 1'b1;
      sda_out <= 1'b0;
    end
    else
    begin
      scl_q   <= scl_in;
      sda_q   <= sda_in;
      sda_out <= 1'b0;
    end
  end

  // byte framing, acknowledge and data drive
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      i_state  <= I_IDLE;
      bit_cnt  <= 4'h0;
      shreg    <= 8'h00;
      ptr      <= 8'h00;
      nack     <= 1'b1;
      sda_oe_n <= 1'b1;
    end
    else if (start_c)
    begin
      i_state  <= I_ADDR;
      bit_cnt  <= 4'hF;  // SCL fall after START wraps this to 0, not a data bit
      sda_oe_n <= 1'b1;
    end
    else if (stop_c)
    begin
      i_state  <= I_IDLE;
      sda_oe_n <= 1'b1;
    end
    else if (scl_rise)
    begin
      if (receiving && (bit_cnt != 4'h8))
        shreg <= {shreg[6:0], sda_in};
      if ((i_state == I_READ) && (bit_cnt == 4'h8))
        nack <= sda_in;
    end
    else if (scl_fall && (i_state != I_IDLE))
    begin
      bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
      if (bit_cnt == 4'h7)
      begin
        if (i_state == I_READ)
        begin
          sda_oe_n <= 1'b1;
          ptr      <= ptr + 8'h01;
        end
        else if ((i_state == I_ADDR) && !addr_match)
          i_state <= I_IDLE;
        else
        begin
          sda_oe_n <= 1'b0;
          if (i_state == I_WORD)
            ptr <= shreg;
          else if (i_state == I_WRITE)
            ptr <= ptr + 8'h01;
        end
      end
      else if (bit_cnt == 4'h8)
      begin
        if (i_state == I_ADDR)
        begin
          i_state  <= shreg[0] ? I_READ : I_WORD;
          sda_oe_n <= shreg[0] ? pd_rdata[7] : 1'b1;
        end
        else if ((i_state == I_READ) && nack)
        begin
          i_state  <= I_IDLE;
          sda_oe_n <= 1'b1;
        end
        else if (i_state == I_READ)
          sda_oe_n <= pd_rdata[7];
        else
        begin
          i_state  <= I_WRITE;
          sda_oe_n <= 1'b1;
        end
      end
      else if (i_state == I_READ)
        sda_oe_n <= pd_rdata[3'(3'h6 - bit_cnt[2:0])];
    end
  end

  a_addr_reject: assert property (scl_fall && !start_c && !stop_c && (i_state == I_ADDR)
    && (bit_cnt == 4'h7) && !addr_match |=> (i_state == I_IDLE) && sda_oe_n)
    else $error("foreign slave address acknowledged");
endmodule

// ---- include/rsdp_regs.svh ----
// Constants of the registered module port: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef RSDP_REGS_SVH
`define RSDP_REGS_SVH

// ----------------------------------------
// Register offsets (byte addresses)
// ----------------------------------------
`define RSDP_MODE_OFS   8'h00
`define RSDP_STATUS_OFS 8'h04

// ----------------------------------------
// Field positions
// ----------------------------------------
`define RSDP_MODE_LEN   0
`define RSDP_MODE_CL3   3
`define RSDP_ST_BANK    0
`define RSDP_ST_PWR     4
`define RSDP_ST_BURST   6
`define RSDP_ST_LATCH   7
`define RSDP_ST_LAT     8

// ----------------------------------------
// Reset values and codes
// ----------------------------------------
`define RSDP_MODE_RST   4'hB
`define RSDP_LEN_FULL   3'h7
`define RSDP_AP_BIT     10
// Arbitrary device-type code of the presence store
`define RSDP_PD_TYPE    4'hA

// ----------------------------------------
// Widths and timing counts
// ----------------------------------------
`define RSDP_COL_W      9
`define RSDP_DQ_W       72
`define RSDP_FIFO_DEPTH 4
`define RSDP_PD_BYTES   256
`define RSDP_CL_FAST    3'h2
`define RSDP_CL_SLOW    3'h3

`endif

// ---- include/rsdp_pkg.sv ----
// Types shared by the registered module port.
// Assumes rsdp_regs.svh sits on the include path.
`include "rsdp_regs.svh"

package rsdp_pkg;

  // ----------------------------------------
  // Command bundle on host and memory sides
  // ----------------------------------------
  typedef struct packed {
    logic        cs_n;
    logic        ras_n;
    logic        cas_n;
    logic        we_n;
    logic        cke;
    logic [1:0]  bank;
    logic [11:0] row_column_address;
  } rsdp_cmd_type;

  localparam rsdp_cmd_type RSDP_CMD_IDLE = rsdp_cmd_type'({5'h1F, 14'h0000});

  typedef enum logic [2:0] {
    OP_NOP   = 3'b000,
    OP_ACT   = 3'b001,
    OP_READ  = 3'b010,
    OP_WRITE = 3'b011,
    OP_BTERM = 3'b100,
    OP_PRE   = 3'b101,
    OP_REF   = 3'b110,
    OP_MRS   = 3'b111
  } rsdp_op_type;

  typedef enum logic [1:0] {
    PS_IDLE = 2'b00,
    PS_AREF = 2'b01,
    PS_SELF = 2'b10,
    PS_DOWN = 2'b11
  } rsdp_pwr_type;

  typedef enum logic [2:0] {
    I_IDLE  = 3'b000,
    I_ADDR  = 3'b001,
    I_WORD  = 3'b010,
    I_WRITE = 3'b011,
    I_READ  = 3'b100
  } rsdp_i2c_type;

  // Command decode from the strobe pattern
  function automatic rsdp_op_type rsdp_decode(input rsdp_cmd_type c);
    rsdp_op_type op;
    op = OP_NOP;
    if (!c.cs_n)
    begin
      case ({c.ras_n, c.cas_n, c.we_n})
        3'b011:  op = OP_ACT;
        3'b101:  op = OP_READ;
        3'b100:  op = OP_WRITE;
        3'b110:  op = OP_BTERM;
        3'b010:  op = OP_PRE;
        3'b001:  op = OP_REF;
        3'b000:  op = OP_MRS;
        default: op = OP_NOP;
      endcase
    end
    return op;
  endfunction

endpackage

// ---- hdl/rsdp_fifo.sv ----
// Write-data FIFO with valid and ready on both sides.
// Assumes a power-of-two depth; one clock, asynchronous active-low reset.
`timescale 1ns/1ns

module rsdp_fifo
#(
  parameter int WIDTH = 72,
  parameter int DEPTH = 4
)
(
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic [WIDTH-1:0] in_data,
  input  wire logic             in_valid,
  output logic                  in_ready,
  output logic [WIDTH-1:0]      out_data,
  output logic                  out_valid,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] store [DEPTH];
  logic [AW-1:0]    wr_ptr;
  logic [AW-1:0]    rd_ptr;
  logic [AW:0]      count;
  logic [AW:0]      next_count;
  logic             push;
  logic             pop;

  // Handshakes and occupancy
  assign push       = in_valid & in_ready;
  assign pop        = out_valid & out_ready;
  assign out_valid  = (count != '0);
  assign out_data   = store[rd_ptr];
  assign next_count = count + (AW+1)'(push) - (AW+1)'(pop);

  // Ready registered so the source sees full one cycle early enough
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr   <= '0;
      rd_ptr   <= '0;
      count    <= '0;
      in_ready <= 1'b1;
    end
    else
    begin
      wr_ptr   <= push ? wr_ptr + 1'b1 : wr_ptr;
      rd_ptr   <= pop ? rd_ptr + 1'b1 : rd_ptr;
      count    <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
    end
  end

  // Storage needs no reset
  always_ff @(posedge clk)
  begin
    if (push)
      store[wr_ptr] <= in_data;
  end
endmodule

// ---- hdl/rsdp_store.sv ----
// Byte memory behind the presence-detect slave, read data from a register.
// Assumes one writer and one reader address.
`timescale 1ns/1ns
`include "rsdp_regs.svh"

module rsdp_store
(
  input  wire logic       clk,
  input  wire logic       we,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  output logic [7:0]      rdata
);
  logic [7:0] bytes [`RSDP_PD_BYTES];

  // Registered read, write-first is not needed by the slave
  always_ff @(posedge clk)
  begin
    if (we)
      bytes[addr] <= wdata;
    rdata <= bytes[addr];
  end
endmodule

// ---- sim/rsdp_host_model.sv ----
// Host partner: issues one command per call and pushes write words.
// Assumes hclk from the bench; outputs change just after a rising edge.
`timescale 1ns/1ns

module rsdp_host_model
  import rsdp_pkg::*;
(
  input  wire logic    hclk,
  input  wire logic    wdata_ready,
  output rsdp_cmd_type host_cmd,
  output logic [71:0]  wdata_in,
  output logic         wdata_valid,
  input  wire logic    sda_line,
  output logic         scl,
  output logic         sda_drv
);
  // Quiet outputs from time zero
  initial
  begin
    host_cmd    = RSDP_CMD_IDLE;
    wdata_in    = 72'h0;
    wdata_valid = 1'b0;
    scl         = 1'b1;
    sda_drv     = 1'b1;
  end

  // self refresh: refresh with clock enable low, kept low a while
  task automatic sleep();
    @(posedge hclk);
    host_cmd <= {1'b0, 3'b001, 1'b0, 2'h0, 12'h000};
    @(posedge hclk);
    host_cmd <= {4'hF, 1'b0, 14'h0000};
    repeat (4) @(posedge hclk);
    host_cmd <= RSDP_CMD_IDLE;
  endtask

  // system master; SDA moves only while SCL is low
  task automatic i2c_bit(input logic b, output logic r);
    @(posedge hclk);
    sda_drv <= b;
    repeat (2) @(posedge hclk);
    scl <= 1'b1;
    repeat (2) @(posedge hclk);
    r = sda_line;
    scl <= 1'b0;
  endtask

  // START when stop is low, STOP when high; SDA moves while SCL is high
  task automatic i2c_cond(input logic stop);
    @(posedge hclk);
    sda_drv <= !stop;
    repeat (2) @(posedge hclk);
    scl <= 1'b1;
    repeat (2) @(posedge hclk);
    sda_drv <= stop;
    repeat (2) @(posedge hclk);
    scl <= stop;
  endtask

  // byte MSB first, then ninth bit: m_ack driven, line level returned
  task automatic i2c_byte(input logic [7:0] b, input logic m_ack, output logic [7:0] r, output logic ack);
    for (int i = 7; i >= 0; i--)
      i2c_bit(b[i], r[i]);
    i2c_bit(m_ack, ack);
  endtask

  // caller opens rows first
  // One command for a single cycle, then deselect
  task automatic cmd(input logic [2:0] rcw, input logic [1:0] b, input logic [11:0] a);
    @(posedge hclk);
    host_cmd <= {1'b0, rcw, 1'b1, b, a};
    @(posedge hclk);
    host_cmd <= RSDP_CMD_IDLE;
  endtask

  // Word held until taken; data inverted once released
  task automatic push(input logic [71:0] w);
    @(posedge hclk);
    wdata_in    <= w;
    wdata_valid <= 1'b1;
    do @(posedge hclk); while (wdata_ready !== 1'b1);
    wdata_valid <= 1'b0;
    wdata_in    <= ~w;
  endtask
endmodule

// ---- sim/tb_top.sv ----
// Bench: register bus, command forwarding, bursts and write FIFO.
// Assumes package, design and host model are compiled first.
`timescale 1ns/1ns
`include "rsdp_regs.svh"

`define CHK(a, b) begin samples_checked++; if ((a) !== (b)) begin n_mismatch++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end

module tb_top
  import rsdp_pkg::*;
;
  logic           hclk, hresetn, hsel, hwrite, pin, mem_wready;
  logic [31:0]    haddr, hwdata, hrdata, rd;
  logic [1:0]     htrans;
  logic           hreadyout, hresp, burst_valid, wdata_valid, wdata_ready;
  logic           mem_wvalid, sda_out, sda_oe_n;
  logic           scl, sda_drv, pd_ack;
  logic [7:0]     pd_byte;
  logic [8:0]     burst_col;
  logic [71:0]    wdata_in, mem_wdata;
  rsdp_cmd_type   host_cmd, mem_cmd;
  int             n_mismatch, samples_checked;

  rsdp_top rsdp_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'b010), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .input_latch_mode_pin(pin), .host_cmd(host_cmd),
    .mem_cmd(mem_cmd), .burst_col(burst_col), .burst_valid(burst_valid), .wdata_in(wdata_in),
    .wdata_valid(wdata_valid), .wdata_ready(wdata_ready), .mem_wdata(mem_wdata),
    .mem_wvalid(mem_wvalid), .mem_wready(mem_wready), .scl_in(scl), .sda_in(sda_drv & sda_oe_n),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .presence_slave_addr_strap(3'h0));

  rsdp_host_model rsdp_host_model_i (.hclk(hclk), .wdata_ready(wdata_ready), .host_cmd(host_cmd),
    .wdata_in(wdata_in), .wdata_valid(wdata_valid), .sda_line(sda_drv & sda_oe_n), .scl(scl),
    .sda_drv(sda_drv));

  // 25 MHz clock
  always #20 hclk = ~hclk;

  // One single AHB-Lite transfer; waits only on hready
  task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask

  task automatic summarize();
    $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // Hang guard, far beyond the few hundred cycles needed
  initial
  begin
    #(40 * 5000);
    n_mismatch++;
    summarize();
  end

  // Main sequence
  initial
  begin
    {hclk, hresetn, hsel, hwrite, pin, mem_wready, htrans} = 8'h00;
    {haddr, hwdata} = 64'h0;
    n_mismatch = 0;
    samples_checked = 0;
    repeat (12) @(posedge hclk);
    hresetn <= 1'b1;
    `CHK(mem_cmd, RSDP_CMD_IDLE)
    `CHK({hreadyout, hresp, wdata_ready, mem_wvalid, sda_oe_n}, 5'b10101)
    // Mode register, latency field and an unmapped place
    xfer(1'b0, 32'h00, 32'h0);
    `CHK(rd, 32'h0000000B)
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[10:8], 3'h3)
    xfer(1'b1, 32'h00, 32'h2);
    xfer(1'b0, 32'h00, 32'h0);
    `CHK(rd, 32'h00000002)
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[10:8], 3'h2)
    xfer(1'b1, 32'h08, 32'hFFFFFFFF);
    xfer(1'b0, 32'h08, 32'h0);
    `CHK(rd, 32'h0)
    // Buffered then registered forwarding of ACTIVE
    rsdp_host_model_i.cmd(3'b011, 2'h1, 12'h123);
    #1 `CHK(mem_cmd, {1'b0, 3'b011, 1'b1, 2'h1, 12'h123})
    pin <= 1'b1;
    rsdp_host_model_i.cmd(3'b011, 2'h2, 12'hABC);
    #1 `CHK(mem_cmd, RSDP_CMD_IDLE)
    @(posedge hclk);
    #1 `CHK(mem_cmd, {1'b0, 3'b011, 1'b1, 2'h2, 12'hABC})
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[7:0], 8'h86)
    `CHK(rd[10:8], 3'h3)
    pin <= 1'b0;
    // Close one bank while the other stays open
    rsdp_host_model_i.cmd(3'b010, 2'h1, 12'h000);
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[3:0], 4'h4)
    // Burst of four from column 5 with auto precharge
    rsdp_host_model_i.cmd(3'b101, 2'h2, 12'h405);
    #1;
    while (burst_valid !== 1'b1)
    begin
      @(posedge hclk);
      #1;
    end
    for (int i = 0; i < 4; i++)
    begin
      `CHK(burst_col, 9'h004 + 9'((i + 1) % 4))
      @(posedge hclk);
      #1;
    end
    `CHK(burst_valid, 1'b0)
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[3:0], 4'h0)
    // Write burst on bank 3, a read restarting it mid-burst, recovery, precharge
    rsdp_host_model_i.cmd(3'b011, 2'h3, 12'h010);
    rsdp_host_model_i.cmd(3'b100, 2'h3, 12'h00A);
    #1 `CHK(burst_col, 9'h00A)
    rsdp_host_model_i.cmd(3'b101, 2'h3, 12'h003);
    #1 `CHK(burst_col, 9'h003)
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[3:0], 4'h8)
    repeat (3) @(posedge hclk); // three clocks of write recovery
    rsdp_host_model_i.cmd(3'b010, 2'h3, 12'h000);
    xfer(1'b0, 32'h04, 32'h0);
    `CHK(rd[3:0], 4'h0)
    // Self refresh seen in status while clock enable stays low
    fork
      rsdp_host_model_i.sleep();
      begin
        @(posedge hclk);
        xfer(1'b0, 32'h04, 32'h0);
      end
    join
    `CHK(rd[5:4], 2'h2)
    // Far side stalled: four words in the FIFO plus one in the output stage
    for (int i = 0; i < 5; i++)
      rsdp_host_model_i.push(72'h5A00 + 72'(i));
    repeat (2) @(posedge hclk);
    `CHK(wdata_ready, 1'b0)
    mem_wready <= 1'b1;
    for (int i = 0; i < 5; i++)
    begin
      do @(posedge hclk); while (mem_wvalid !== 1'b1);
      `CHK(mem_wdata, 72'h5A00 + 72'(i))
    end
    mem_wready <= 1'b0;
    repeat (2) @(posedge hclk);
    #1 `CHK(mem_wvalid, 1'b0)
    // Presence store: foreign address refused, user byte written, read back
    rsdp_host_model_i.i2c_cond(1'b0);
    rsdp_host_model_i.i2c_byte(8'hA6, 1'b1, pd_byte, pd_ack);
    `CHK(pd_ack, 1'b1)
    rsdp_host_model_i.i2c_cond(1'b0);
    rsdp_host_model_i.i2c_byte(8'hA0, 1'b1, pd_byte, pd_ack);
    `CHK({pd_ack, sda_out}, 2'b00)
    rsdp_host_model_i.i2c_byte(8'hC3, 1'b1, pd_byte, pd_ack);
    rsdp_host_model_i.i2c_byte(8'h5E, 1'b1, pd_byte, pd_ack);
    `CHK(pd_ack, 1'b0)
    rsdp_host_model_i.i2c_cond(1'b0);
    rsdp_host_model_i.i2c_byte(8'hA0, 1'b1, pd_byte, pd_ack);
    rsdp_host_model_i.i2c_byte(8'hC3, 1'b1, pd_byte, pd_ack);
    rsdp_host_model_i.i2c_cond(1'b0);
    rsdp_host_model_i.i2c_byte(8'hA1, 1'b1, pd_byte, pd_ack);
    rsdp_host_model_i.i2c_byte(8'hFF, 1'b1, pd_byte, pd_ack);
    `CHK(pd_byte, 8'h5E)
    rsdp_host_model_i.i2c_cond(1'b1);
    summarize();
  end
endmodule
